//--- include/bcfg_map.svh
`ifndef BCFG_MAP_SVH
`define BCFG_MAP_SVH

`define BCFG_CH1_CONF_IDX 10'h005
`define BCFG_CH2_CTRL_IDX 10'h006
`define BCFG_CH2_CONF_IDX 10'h007
`define BCFG_STATUS_IDX 10'h010

`define BCFG_CONF_RST 8'h22
`define BCFG_CTRL_RST 8'h22
`define BCFG_CONF_WMASK 8'h3f
`define BCFG_CTRL_WMASK 8'hbb

`define BCFG_CURRENT_LIMIT_COMPARATOR_MSB 5
`define BCFG_CURRENT_LIMIT_COMPARATOR_LSB 3
`define BCFG_SLEW_MSB 2
`define BCFG_SLEW_LSB 0
`define BCFG_RV_BIT 7
`define BCFG_PLDN_BIT 5
`define BCFG_VMON_BIT 4
`define BCFG_VSEL_BIT 3
`define BCFG_FPWM_BIT 1
`define BCFG_EN_BIT 0

`define BCFG_CURRENT_LIMIT_COMPARATOR_MIN_CODE 3'h2

`define BCFG_CLK_MHZ 200
`define BCFG_VSTEP_UV 5000
`define BCFG_SLEW0_UV_US 33000
`define BCFG_SLEW1_UV_US 20000
`define BCFG_SLEW2_UV_US 10000
`define BCFG_SLEW3_UV_US 5000
`define BCFG_SLEW4_UV_US 2500
`define BCFG_SLEW5_UV_US 1300
`define BCFG_SLEW6_UV_US 630
`define BCFG_SLEW7_UV_US 310

`endif

//--- include/bcfg_pkg.sv
package bcfg_pkg;

  typedef logic [7:0] bcfg_byte_t;
  typedef logic [2:0] bcfg_code_t;
  typedef logic [11:0] bcfg_cnt_t;

  typedef enum logic [2:0] {
    BCFG_RAMP_IDLE = 3'b001,
    BCFG_RAMP_WAIT = 3'b010,
    BCFG_RAMP_STEP = 3'b100
  } bcfg_ramp_e;

endpackage

//--- design/bcfg_slew_ramp.sv
`timescale 1ns/1ps
module bcfg_slew_ramp
  import bcfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire bcfg_byte_t target,
  input wire bcfg_cnt_t step_cycles,
  output bcfg_byte_t level_q,
  output logic settled_q
);

  bcfg_ramp_e state_q;
  bcfg_ramp_e state_d;
  bcfg_cnt_t cnt_q;
  bcfg_cnt_t cnt_d;
  bcfg_byte_t level_d;
  wire differs = (level_q != target);
  wire going_up = (level_q < target);

  // One code step per slew period, same pace up and down
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    level_d = level_q;
    case (state_q)
      BCFG_RAMP_IDLE: begin
        if (differs) begin
          cnt_d = step_cycles;
          state_d = BCFG_RAMP_WAIT;
        end
      end
      BCFG_RAMP_WAIT: begin
        cnt_d = cnt_q - 12'h001;
        if (cnt_q <= 12'h001) begin
          state_d = BCFG_RAMP_STEP;
        end
      end
      BCFG_RAMP_STEP: begin
        if (differs) begin
          level_d = going_up ? level_q + 8'h01 : level_q - 8'h01;
        end
        state_d = BCFG_RAMP_IDLE;
      end
      default: begin
        state_d = BCFG_RAMP_IDLE;
      end
    endcase
    // Disabled output is discharged, so the ramp restarts from zero
    if (!run) begin
      level_d = 8'h00;
      state_d = BCFG_RAMP_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= BCFG_RAMP_IDLE;
      cnt_q <= 12'h000;
      level_q <= 8'h00;
      settled_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      level_q <= level_d;
      settled_q <= (level_d == target);
    end
  end

endmodule

//--- design/bcfg_regs.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "bcfg_map.svh"
module bcfg_regs
  import bcfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Default load from non-volatile memory
  input wire logic nvm_load,
  input wire bcfg_byte_t nvm_ch1_conf,
  input wire bcfg_byte_t nvm_ch2_ctrl,
  input wire bcfg_byte_t nvm_ch2_conf,
  // Device settings and voltage targets
  input wire bcfg_code_t current_limit_comparator_ceiling,
  input wire logic ch1_regulator_on,
  input wire bcfg_byte_t ch1_target_voltage,
  input wire bcfg_byte_t ch2_target_voltage_a,
  input wire bcfg_byte_t ch2_target_voltage_b,
  // Channel one controls
  output bcfg_code_t ch1_peak_current_limit,
  output bcfg_code_t ch1_voltage_slew,
  output bcfg_byte_t ch1_output_level,
  // Channel two controls
  output bcfg_code_t ch2_peak_current_limit,
  output bcfg_code_t ch2_voltage_slew,
  output logic ch2_residual_check_on,
  output logic ch2_output_pulldown_on,
  output logic ch2_monitor_comparators_on,
  output logic ch2_target_register_select,
  output logic ch2_forced_pwm,
  output logic ch2_regulator_on,
  output bcfg_byte_t ch2_output_level
);

  bcfg_byte_t ch1_conf_q;
  bcfg_byte_t ch1_conf_d;
  bcfg_byte_t ch2_ctrl_q;
  bcfg_byte_t ch2_ctrl_d;
  bcfg_byte_t ch2_conf_q;
  bcfg_byte_t ch2_conf_d;
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  bcfg_code_t ch1_current_limit_comparator_d;
  bcfg_code_t ch2_current_limit_comparator_d;
  logic ch2_pulldown_d;
  bcfg_byte_t ch1_level;
  bcfg_byte_t ch2_level;
  logic ch1_settled;
  logic ch2_settled;
  bcfg_byte_t ch2_target;
  bcfg_cnt_t ch1_step;
  bcfg_cnt_t ch2_step;

  // Reset images, sliced per field for the output flops
  localparam bcfg_byte_t CONF_RST = `BCFG_CONF_RST;
  localparam bcfg_byte_t CTRL_RST = `BCFG_CTRL_RST;

  // Cycles per output code step, rounded up so the rate is never exceeded
  function automatic bcfg_cnt_t step_cycles(input bcfg_code_t code);
    int rate;
    int cyc;
    rate = `BCFG_SLEW0_UV_US;
    case (code)
      3'h0: rate = `BCFG_SLEW0_UV_US;
      3'h1: rate = `BCFG_SLEW1_UV_US;
      3'h2: rate = `BCFG_SLEW2_UV_US;
      3'h3: rate = `BCFG_SLEW3_UV_US;
      3'h4: rate = `BCFG_SLEW4_UV_US;
      3'h5: rate = `BCFG_SLEW5_UV_US;
      3'h6: rate = `BCFG_SLEW6_UV_US;
      default: rate = `BCFG_SLEW7_UV_US;
    endcase
    cyc = (`BCFG_VSTEP_UV * `BCFG_CLK_MHZ + rate - 1) / rate;
    if (cyc < 1) begin
      cyc = 1;
    end
    return cyc[11:0];
  endfunction

  // Reserved codes and settings above the ceiling both limit the code
  function automatic bcfg_code_t eff_current_limit_comparator(input bcfg_code_t prog, input bcfg_code_t ceil);
    bcfg_code_t c;
    c = prog;
    if (c < `BCFG_CURRENT_LIMIT_COMPARATOR_MIN_CODE) begin
      c = `BCFG_CURRENT_LIMIT_COMPARATOR_MIN_CODE;
    end
    if (c > ceil) begin
      c = ceil;
    end
    if (c < `BCFG_CURRENT_LIMIT_COMPARATOR_MIN_CODE) begin
      c = `BCFG_CURRENT_LIMIT_COMPARATOR_MIN_CODE;
    end
    return c;
  endfunction

  // Address decode
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr_en = access & pwrite & pstrb[0];
  wire hit_c1 = (paddr == {`BCFG_CH1_CONF_IDX, 2'b00});
  wire hit_c2c = (paddr == {`BCFG_CH2_CTRL_IDX, 2'b00});
  wire hit_c2f = (paddr == {`BCFG_CH2_CONF_IDX, 2'b00});
  wire hit_st = (paddr == {`BCFG_STATUS_IDX, 2'b00});
  wire mapped = hit_c1 | hit_c2c | hit_c2f | hit_st;
  wire wr_c1 = wr_en & hit_c1;
  wire wr_c2c = wr_en & hit_c2c;
  wire wr_c2f = wr_en & hit_c2f;
  wire st_wr = pwrite & hit_st;

  // Writes are masked so reserved bits never hold a one
  wire [7:0] wbyte = pwdata[7:0];
  wire [7:0] conf_w = wbyte & `BCFG_CONF_WMASK;
  wire [7:0] ctrl_w = wbyte & `BCFG_CTRL_WMASK;

  // Status word: ramp levels and settled flags
  wire [31:0] status_word = {
    6'h00, ch2_settled, ch1_settled,
    ch2_level, ch1_level,
    ch2_peak_current_limit, ch1_peak_current_limit,
    ch2_output_pulldown_on, ch2_regulator_on
  };

  wire [31:0] rd_mux =
    hit_c1 ? {24'h00_0000, ch1_conf_q} :
    hit_c2c ? {24'h00_0000, ch2_ctrl_q} :
    hit_c2f ? {24'h00_0000, ch2_conf_q} :
    hit_st ? status_word :
    32'h0000_0000;

  // NVM image first, a bus write in the same cycle lands on top
  always_comb begin
    ch1_conf_d = ch1_conf_q;
    ch2_ctrl_d = ch2_ctrl_q;
    ch2_conf_d = ch2_conf_q;
    if (nvm_load) begin
      ch1_conf_d = nvm_ch1_conf & `BCFG_CONF_WMASK;
      ch2_ctrl_d = nvm_ch2_ctrl & `BCFG_CTRL_WMASK;
      ch2_conf_d = nvm_ch2_conf & `BCFG_CONF_WMASK;
    end
    if (wr_c1) begin
      ch1_conf_d = conf_w;
    end
    if (wr_c2c) begin
      ch2_ctrl_d = ctrl_w;
    end
    if (wr_c2f) begin
      ch2_conf_d = conf_w;
    end
  end

  // No wait state: answer is ready in the first access cycle
  always_comb begin
    pready_d = setup;
    pslverr_d = setup & (~mapped | st_wr);
    prdata_d = 32'h0000_0000;
    if (setup && !pwrite) begin
      prdata_d = rd_mux;
    end
  end

  // Fields of the next register values
  wire [2:0] ch1_current_limit_comparator_prog = ch1_conf_d[`BCFG_CURRENT_LIMIT_COMPARATOR_MSB:`BCFG_CURRENT_LIMIT_COMPARATOR_LSB];
  wire [2:0] ch2_current_limit_comparator_prog = ch2_conf_d[`BCFG_CURRENT_LIMIT_COMPARATOR_MSB:`BCFG_CURRENT_LIMIT_COMPARATOR_LSB];
  wire [2:0] ch1_slew_next = ch1_conf_d[`BCFG_SLEW_MSB:`BCFG_SLEW_LSB];
  wire [2:0] ch2_slew_next = ch2_conf_d[`BCFG_SLEW_MSB:`BCFG_SLEW_LSB];

  // Live limits follow the register without waiting for a disable
  always_comb begin
    ch1_current_limit_comparator_d = eff_current_limit_comparator(ch1_current_limit_comparator_prog, current_limit_comparator_ceiling);
    ch2_current_limit_comparator_d = eff_current_limit_comparator(ch2_current_limit_comparator_prog, current_limit_comparator_ceiling);
    ch2_pulldown_d = ch2_ctrl_d[`BCFG_PLDN_BIT] & ~ch2_ctrl_d[`BCFG_EN_BIT];
  end

  // Target picks one of two voltage registers
  assign ch2_target = ch2_ctrl_q[`BCFG_VSEL_BIT] ? ch2_target_voltage_b : ch2_target_voltage_a;
  assign ch1_step = step_cycles(ch1_conf_q[`BCFG_SLEW_MSB:`BCFG_SLEW_LSB]);
  assign ch2_step = step_cycles(ch2_conf_q[`BCFG_SLEW_MSB:`BCFG_SLEW_LSB]);

  // Reset mirrors the defaults until a non-volatile load arrives
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch1_conf_q <= `BCFG_CONF_RST;
    end else begin
      ch1_conf_q <= ch1_conf_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch2_ctrl_q <= `BCFG_CTRL_RST;
    end else begin
      ch2_ctrl_q <= ch2_ctrl_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch2_conf_q <= `BCFG_CONF_RST;
    end else begin
      ch2_conf_q <= ch2_conf_d;
    end
  end

  // Read data is zero outside the access cycle, so a stale word never shows
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= prdata_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_d;
    end
  end

  // Outputs take the next register value (limits clamped, pulldown gated) so they stay flop driven
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch1_peak_current_limit <= CONF_RST[`BCFG_CURRENT_LIMIT_COMPARATOR_MSB:`BCFG_CURRENT_LIMIT_COMPARATOR_LSB];
    end else begin
      ch1_peak_current_limit <= ch1_current_limit_comparator_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch1_voltage_slew <= CONF_RST[`BCFG_SLEW_MSB:`BCFG_SLEW_LSB];
    end else begin
      ch1_voltage_slew <= ch1_slew_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch2_peak_current_limit <= CONF_RST[`BCFG_CURRENT_LIMIT_COMPARATOR_MSB:`BCFG_CURRENT_LIMIT_COMPARATOR_LSB];
    end else begin
      ch2_peak_current_limit <= ch2_current_limit_comparator_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch2_voltage_slew <= CONF_RST[`BCFG_SLEW_MSB:`BCFG_SLEW_LSB];
    end else begin
      ch2_voltage_slew <= ch2_slew_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch2_residual_check_on <= CTRL_RST[`BCFG_RV_BIT];
    end else begin
      ch2_residual_check_on <= ch2_ctrl_d[`BCFG_RV_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch2_output_pulldown_on <= CTRL_RST[`BCFG_PLDN_BIT] & ~CTRL_RST[`BCFG_EN_BIT];
    end else begin
      ch2_output_pulldown_on <= ch2_pulldown_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch2_monitor_comparators_on <= CTRL_RST[`BCFG_VMON_BIT];
    end else begin
      ch2_monitor_comparators_on <= ch2_ctrl_d[`BCFG_VMON_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch2_target_register_select <= CTRL_RST[`BCFG_VSEL_BIT];
    end else begin
      ch2_target_register_select <= ch2_ctrl_d[`BCFG_VSEL_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch2_forced_pwm <= CTRL_RST[`BCFG_FPWM_BIT];
    end else begin
      ch2_forced_pwm <= ch2_ctrl_d[`BCFG_FPWM_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch2_regulator_on <= CTRL_RST[`BCFG_EN_BIT];
    end else begin
      ch2_regulator_on <= ch2_ctrl_d[`BCFG_EN_BIT];
    end
  end

  // Ramps run only while their channel is on
  bcfg_slew_ramp u_ramp1 (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .run(ch1_regulator_on),
    .target(ch1_target_voltage),
    .step_cycles(ch1_step),
    .level_q(ch1_level),
    .settled_q(ch1_settled)
  );

  bcfg_slew_ramp u_ramp2 (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .run(ch2_regulator_on),
    .target(ch2_target),
    .step_cycles(ch2_step),
    .level_q(ch2_level),
    .settled_q(ch2_settled)
  );

  assign ch1_output_level = ch1_level;
  assign ch2_output_level = ch2_level;

endmodule

//--- tb/bcfg_regs_checker.sv
`timescale 1ns/1ps
module bcfg_regs_checker
  import bcfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire bcfg_code_t current_limit_comparator_ceiling,
  input wire bcfg_code_t ch2_peak_current_limit,
  input wire bcfg_code_t ch2_voltage_slew,
  input wire logic ch2_output_pulldown_on,
  input wire logic ch2_forced_pwm,
  input wire logic ch2_regulator_on,
  input wire bcfg_byte_t ch2_output_level
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence wr_s(a);
    psel && penable && pready && pwrite && pstrb[0] && paddr == a;
  endsequence
  chk_ready_after_setup: assert property (setup_s |=> pready ##1 !pready) else $error("ready timing");
  chk_err_unmapped: assert property (setup_s ##0 paddr == 12'h020 |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access");
  chk_ctrl_write: assert property (wr_s(12'h018) |=> ch2_regulator_on == $past(pwdata[0]) &&
    ch2_forced_pwm == $past(pwdata[1])) else $error("control write");
  chk_pulldown_off: assert property (ch2_regulator_on |-> !ch2_output_pulldown_on) else $error("pulldown");
  chk_slew_write: assert property (wr_s(12'h01c) |=> ch2_voltage_slew == $past(pwdata[2:0]))
    else $error("slew write");
  chk_current_limit_comparator_floor: assert property (ch2_peak_current_limit >= 3'h2) else $error("limit floor");
  chk_current_limit_comparator_ceiling: assert property ($stable(current_limit_comparator_ceiling) && !$past(sys_rst) |->
    ch2_peak_current_limit <= (current_limit_comparator_ceiling < 3'h2 ? 3'h2 : current_limit_comparator_ceiling)) else $error("limit clamp");
  chk_level_off: assert property (!ch2_regulator_on [*2] |-> ch2_output_level == 8'h00) else $error("level off");
  chk_ramp_step: assert property (ch2_regulator_on [*3] |-> ch2_output_level == $past(ch2_output_level) ||
    ch2_output_level == $past(ch2_output_level) + 8'h01 || ch2_output_level == $past(ch2_output_level) - 8'h01)
    else $error("ramp step");
endmodule

bind bcfg_regs bcfg_regs_checker bcfg_regs_checker_i (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .current_limit_comparator_ceiling, .ch2_peak_current_limit, .ch2_voltage_slew,
  .ch2_output_pulldown_on, .ch2_forced_pwm, .ch2_regulator_on, .ch2_output_level);

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import bcfg_pkg::*;
  logic sys_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nvm_load = 1'b0;
  logic ch1_regulator_on = 1'b0, pready, pslverr, err, ch2_residual_check_on, ch2_output_pulldown_on;
  logic ch2_monitor_comparators_on, ch2_target_register_select, ch2_forced_pwm, ch2_regulator_on;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  bcfg_byte_t nvm_ch1_conf = '0, nvm_ch2_ctrl = '0, nvm_ch2_conf = '0, ch1_target_voltage = '0;
  bcfg_byte_t ch2_target_voltage_a = '0, ch2_target_voltage_b = '0, ch1_output_level, ch2_output_level;
  bcfg_code_t current_limit_comparator_ceiling = 3'h7, ch1_peak_current_limit, ch1_voltage_slew, ch2_peak_current_limit;
  bcfg_code_t ch2_voltage_slew;
  int n_fail = 0, total_checks = 0, cyc = 0;
  // Control outputs in bit order 7,5,4,3,1,0 of the control register
  wire [5:0] ctl = {ch2_residual_check_on, ch2_output_pulldown_on, ch2_monitor_comparators_on,
    ch2_target_register_select, ch2_forced_pwm, ch2_regulator_on};

  bcfg_regs bcfg_regs_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nvm_load(nvm_load),
    .nvm_ch1_conf(nvm_ch1_conf), .nvm_ch2_ctrl(nvm_ch2_ctrl), .nvm_ch2_conf(nvm_ch2_conf),
    .current_limit_comparator_ceiling(current_limit_comparator_ceiling), .ch1_regulator_on(ch1_regulator_on), .ch1_target_voltage(ch1_target_voltage),
    .ch2_target_voltage_a(ch2_target_voltage_a), .ch2_target_voltage_b(ch2_target_voltage_b),
    .ch1_peak_current_limit(ch1_peak_current_limit), .ch1_voltage_slew(ch1_voltage_slew),
    .ch1_output_level(ch1_output_level), .ch2_peak_current_limit(ch2_peak_current_limit),
    .ch2_voltage_slew(ch2_voltage_slew), .ch2_residual_check_on(ch2_residual_check_on),
    .ch2_output_pulldown_on(ch2_output_pulldown_on), .ch2_monitor_comparators_on(ch2_monitor_comparators_on),
    .ch2_target_register_select(ch2_target_register_select), .ch2_forced_pwm(ch2_forced_pwm),
    .ch2_regulator_on(ch2_regulator_on), .ch2_output_level(ch2_output_level)
  );

  initial forever #2.5 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Hang guard: the ramps here use slew code 0, 33 cycles per step
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish;
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge sys_clk);
  endtask

  // Waits for the ramp and checks the time taken against the step rate
  task automatic wait_level(input bcfg_byte_t v, input int lo, input int hi);
    int n = 0;
    while (ch2_output_level !== v && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    check(ch2_output_level, v);
    check(n >= lo && n <= hi, 1'b1);
  endtask

  task automatic t_defaults;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 12'h014 + 12'(4 * i), '0);
      check(rd, 32'h0000_0022);
    end
    check(ch2_peak_current_limit, 3'h4);
    check(ch2_voltage_slew, 3'h2);
    check(ctl, 6'b010010);
  endtask

  task automatic t_ctrl;
    apb(1'b1, 12'h018, 32'h0000_00ff);
    check(ctl, 6'b101111);
    apb(1'b0, 12'h018, '0);
    check(rd, 32'h0000_00bb);
    apb(1'b1, 12'h018, 32'h0000_0020);
    check(ctl, 6'b010000);
  endtask

  task automatic t_current_limit_comparator;
    apb(1'b1, 12'h018, 32'h0000_0001);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h01c, 32'(c * 8 + 1));
      check(ch2_peak_current_limit, (c < 2) ? 2 : c);
      check(ch2_voltage_slew, 3'h1);
      apb(1'b0, 12'h01c, '0);
      check(rd, 32'(c * 8 + 1));
    end
    @(posedge sys_clk);
    current_limit_comparator_ceiling <= 3'h5;
    repeat (2) @(negedge sys_clk);
    check(ch2_peak_current_limit, 3'h5);
    @(posedge sys_clk);
    current_limit_comparator_ceiling <= 3'h7;
    apb(1'b1, 12'h014, 32'h0000_003b);
    check({ch1_peak_current_limit, ch1_voltage_slew}, 6'h3b);
  endtask

  task automatic t_ramp;
    apb(1'b1, 12'h01c, 32'h0000_0020);
    @(posedge sys_clk);
    ch2_target_voltage_a <= 8'h03;
    ch2_target_voltage_b <= 8'h02;
    wait_level(8'h03, 67, 103);
    @(posedge sys_clk);
    ch2_target_voltage_a <= 8'h01;
    wait_level(8'h01, 34, 70);
    apb(1'b1, 12'h018, 32'h0000_0009);
    wait_level(8'h02, 0, 35);
  endtask

  task automatic t_err;
    apb(1'b0, 12'h020, '0);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
    @(posedge sys_clk);
    pstrb <= 4'h0;
    apb(1'b1, 12'h018, '0);
    check(err, 1'b0);
    check(ctl, 6'b000101);
    @(posedge sys_clk);
    pstrb <= 4'hf;
  endtask

  task automatic t_nvm;
    @(posedge sys_clk);
    nvm_ch2_ctrl <= 8'hff;
    nvm_ch2_conf <= 8'hdb;
    nvm_load <= 1'b1;
    @(posedge sys_clk);
    nvm_load <= 1'b0;
    apb(1'b0, 12'h018, '0);
    check(rd, 32'h0000_00bb);
    apb(1'b0, 12'h01c, '0);
    check(rd, 32'h0000_001b);
    check(ctl, 6'b101111);
    apb(1'b0, 12'h014, '0);
    check(rd, 32'h0000_0000);
    check(ch1_peak_current_limit, 3'h2);
  endtask

  // Channel one ramp, then the status word and its write refusal
  task automatic t_status;
    apb(1'b1, 12'h014, 32'h0000_0020);
    @(posedge sys_clk);
    ch1_regulator_on <= 1'b1;
    ch1_target_voltage <= 8'h01;
    repeat (20) @(negedge sys_clk);
    check(ch1_output_level, 8'h00);
    repeat (20) @(negedge sys_clk);
    check(ch1_output_level, 8'h01);
    apb(1'b0, 12'h040, '0);
    check(err, 1'b0);
    check(rd, 32'h0302_0171);
    apb(1'b1, 12'h040, '0);
    check(err, 1'b1);
  endtask

  // Mid-run reset brings every register back to its default
  task automatic t_reset;
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    check({ch1_output_level, ch2_output_level}, 16'h0000);
    check(pready, 1'b0);
    t_defaults;
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    t_defaults;
    t_ctrl;
    t_current_limit_comparator;
    t_ramp;
    t_err;
    t_nvm;
    t_status;
    t_reset;
    tally_and_finish;
  end
endmodule
